// file: inc/buck_setpoint_defines.svh
`ifndef BUCK_SETPOINT_DEFINES_SVH
`define BUCK_SETPOINT_DEFINES_SVH

`define BUCK2_SETPOINT_ADDR     8'h0F
`define BUCK3_SETPOINT_ADDR     8'h10
`define SETPOINT_EXT_BIT        7
`define SETPOINT_RSVD_BIT       6
`define SETPOINT_CODE_MSB       5
`define BUCK3_SETPOINT_RESET    8'h08
`define BUCK2_CODE_RESET_HIGH   6'h38
`define BUCK2_CODE_RESET_LOW    6'h08
`define UNMAPPED_READ_VALUE     8'h00
`define TARGET_BASE_LOW_MV      12'h384
`define TARGET_STEP_LOW_MV      12'h019
`define TARGET_BASE_MID_MV      12'h5DC
`define TARGET_STEP_MID_MV      12'h032
`define TARGET_TOP_MV           12'hCE4
`define CODE_MID_FIRST          6'h18
`define CODE_HIGH_FIRST         6'h30
`define CODE_TOP_FIRST          6'h38

`endif

// file: inc/buck_setpoint_pkg.sv
`default_nettype none
package buck_setpoint_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        external;
    logic [11:0] target_mv;
  } buck_target_t;

endpackage
`default_nettype wire

// file: core/buck_setpoint_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "buck_setpoint_defines.svh"

module buck_setpoint_registers
  import buck_setpoint_pkg::*;
#(
  parameter bit VARIANT_HIGH_RESET = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire reg_req_t     req,
  input  wire logic         unlock_ok,
  output var  logic [7:0]   rdata_q,
  output var  buck_target_t buck2_q,
  output var  buck_target_t buck3_q
);

  logic [7:0]   b2_reg_q, b2_reg_d, b3_reg_q, b3_reg_d;
  logic [7:0]   rdata_d;
  buck_target_t buck2_d, buck3_d;
  logic         hit2, hit3;

  function automatic logic [11:0] decode_mv(input logic [5:0] code);
    logic [11:0] mv;
    mv = `TARGET_TOP_MV;
    if (code < `CODE_MID_FIRST) begin
      mv = `TARGET_BASE_LOW_MV + 12'(code) * `TARGET_STEP_LOW_MV;
    end else if (code < `CODE_HIGH_FIRST) begin
      mv = `TARGET_BASE_MID_MV
         + 12'(code - `CODE_MID_FIRST) * `TARGET_STEP_MID_MV;
    end else if (code < `CODE_TOP_FIRST) begin
      unique case (code[2:0])
        3'h0: mv = 12'hA8C;
        3'h1: mv = 12'hABE;
        3'h2: mv = 12'hAF0;
        3'h3: mv = 12'hB22;
        3'h4: mv = 12'hB54;
        3'h5: mv = 12'hBB8;
        3'h6: mv = 12'hC1C;
        3'h7: mv = 12'hC80;
      endcase
    end
    return mv;
  endfunction

  // Address match for the two setpoint registers.
  always_comb begin
    hit2 = req.addr == `BUCK2_SETPOINT_ADDR;
    hit3 = req.addr == `BUCK3_SETPOINT_ADDR;
  end

  // A write lands only while the protection is open.
  always_comb begin
    b2_reg_d = b2_reg_q;
    b3_reg_d = b3_reg_q;
    if (req.wr && unlock_ok && hit2) begin
      b2_reg_d = req.wdata;
      b2_reg_d[`SETPOINT_RSVD_BIT] = 1'b0;
    end
    if (req.wr && unlock_ok && hit3) begin
      b3_reg_d = req.wdata;
      b3_reg_d[`SETPOINT_RSVD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      b3_reg_q <= `BUCK3_SETPOINT_RESET;
      b2_reg_q <= {2'h0, VARIANT_HIGH_RESET ? `BUCK2_CODE_RESET_HIGH
                                            : `BUCK2_CODE_RESET_LOW};
    end else begin
      b2_reg_q <= b2_reg_d;
      b3_reg_q <= b3_reg_d;
    end
  end

  // Read data is captured on the read strobe and held until the next read.
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      rdata_d = hit2 ? b2_reg_q : hit3 ? b3_reg_q : `UNMAPPED_READ_VALUE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `UNMAPPED_READ_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Targets follow the stored registers one edge later, zero while external.
  always_comb begin
    buck2_d.external  = b2_reg_q[`SETPOINT_EXT_BIT];
    buck3_d.external  = b3_reg_q[`SETPOINT_EXT_BIT];
    buck2_d.target_mv = b2_reg_q[`SETPOINT_EXT_BIT] ? 12'h000
                      : decode_mv(b2_reg_q[`SETPOINT_CODE_MSB:0]);
    buck3_d.target_mv = b3_reg_q[`SETPOINT_EXT_BIT] ? 12'h000
                      : decode_mv(b3_reg_q[`SETPOINT_CODE_MSB:0]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buck2_q <= '0;
      buck3_q <= '0;
    end else begin
      buck2_q <= buck2_d;
      buck3_q <= buck3_d;
    end
  end

  sequence locked_write2;
    req.wr && !unlock_ok && req.addr == `BUCK2_SETPOINT_ADDR;
  endsequence

  sequence open_write2;
    req.wr && unlock_ok && req.addr == `BUCK2_SETPOINT_ADDR;
  endsequence

  sequence locked_write3;
    req.wr && !unlock_ok && req.addr == `BUCK3_SETPOINT_ADDR;
  endsequence

  sequence open_write3;
    req.wr && unlock_ok && req.addr == `BUCK3_SETPOINT_ADDR;
  endsequence

  a_buck3_reset_value: assert property (
    @(posedge clk)
    rst |=> b3_reg_q == `BUCK3_SETPOINT_RESET
            && rdata_q == `UNMAPPED_READ_VALUE)
    else $error("third setpoint reset value wrong");

  a_buck2_reset_value: assert property (
    @(posedge clk)
    rst |=> b2_reg_q == {2'h0, VARIANT_HIGH_RESET ? `BUCK2_CODE_RESET_HIGH
                                                  : `BUCK2_CODE_RESET_LOW})
    else $error("second setpoint reset value wrong");

  a_locked_write_held: assert property (
    @(posedge clk) disable iff (rst)
    locked_write3 |=> $stable(b3_reg_q))
    else $error("locked write changed third setpoint");

  a_buck2_locked_held: assert property (
    @(posedge clk) disable iff (rst)
    locked_write2 |=> $stable(b2_reg_q))
    else $error("locked write changed second setpoint");

  a_open_write_taken: assert property (
    @(posedge clk) disable iff (rst)
    open_write3 |=> b3_reg_q == {$past(req.wdata[7]), 1'b0,
                                 $past(req.wdata[5:0])})
    else $error("unlocked write not stored");

  a_buck2_write_taken: assert property (
    @(posedge clk) disable iff (rst)
    open_write2 |=> b2_reg_q == {$past(req.wdata[7]), 1'b0,
                                 $past(req.wdata[5:0])})
    else $error("second setpoint write not stored");

  a_unmapped_write_ignored: assert property (
    @(posedge clk) disable iff (rst)
    req.wr && !hit2 && !hit3
    |=> $stable(b2_reg_q) && $stable(b3_reg_q))
    else $error("unmapped write changed a setpoint");

  a_external_ignores_code: assert property (
    @(posedge clk) disable iff (rst)
    b3_reg_q[`SETPOINT_EXT_BIT]
    |=> buck3_q.external && buck3_q.target_mv == 12'h000)
    else $error("external select did not override code");

  a_buck2_external_wins: assert property (
    @(posedge clk) disable iff (rst)
    b2_reg_q[`SETPOINT_EXT_BIT]
    |=> buck2_q.external && buck2_q.target_mv == 12'h000)
    else $error("second external select did not override code");

  a_reserved_reads_zero: assert property (
    @(posedge clk) disable iff (rst)
    req.rd |=> rdata_q[`SETPOINT_RSVD_BIT] == 1'b0)
    else $error("reserved bit read as one");

  a_reserved_held_zero: assert property (
    @(posedge clk) disable iff (rst)
    !b2_reg_q[`SETPOINT_RSVD_BIT]
      && !b3_reg_q[`SETPOINT_RSVD_BIT])
    else $error("reserved bit stored as one");

  a_zero_code_low: assert property (
    @(posedge clk) disable iff (rst)
    b2_reg_q == 8'h00 |=> buck2_q.target_mv == `TARGET_BASE_LOW_MV)
    else $error("zero code not 0.9 V");

  a_low_decode: assert property (
    @(posedge clk) disable iff (rst)
    !b2_reg_q[`SETPOINT_EXT_BIT]
      && b2_reg_q[`SETPOINT_CODE_MSB:0] < `CODE_MID_FIRST
    |=> buck2_q.target_mv == `TARGET_BASE_LOW_MV
        + 12'($past(b2_reg_q[`SETPOINT_CODE_MSB:0])) * `TARGET_STEP_LOW_MV)
    else $error("low range decode wrong");

  a_mid_decode: assert property (
    @(posedge clk) disable iff (rst)
    !b3_reg_q[`SETPOINT_EXT_BIT]
      && b3_reg_q[`SETPOINT_CODE_MSB:0] >= `CODE_MID_FIRST
      && b3_reg_q[`SETPOINT_CODE_MSB:0] < `CODE_HIGH_FIRST
    |=> buck3_q.target_mv == `TARGET_BASE_MID_MV
        + 12'($past(b3_reg_q[`SETPOINT_CODE_MSB:0]) - `CODE_MID_FIRST)
        * `TARGET_STEP_MID_MV)
    else $error("mid range decode wrong");

  a_table_first: assert property (
    @(posedge clk) disable iff (rst)
    !b2_reg_q[`SETPOINT_EXT_BIT]
      && b2_reg_q[`SETPOINT_CODE_MSB:0] == `CODE_HIGH_FIRST
    |=> buck2_q.target_mv == 12'hA8C)
    else $error("first table code not 2.7 V");

  a_top_decode: assert property (
    @(posedge clk) disable iff (rst)
    !b3_reg_q[`SETPOINT_EXT_BIT]
      && b3_reg_q[`SETPOINT_CODE_MSB:0] >= `CODE_TOP_FIRST
    |=> buck3_q.target_mv == `TARGET_TOP_MV)
    else $error("top codes not 3.3 V");

  a_read_no_side: assert property (
    @(posedge clk) disable iff (rst)
    req.rd && !req.wr |=> $stable(b3_reg_q) && $stable(b2_reg_q)
      && rdata_q == ($past(hit3) ? $past(b3_reg_q)
                   : $past(hit2) ? $past(b2_reg_q) : `UNMAPPED_READ_VALUE))
    else $error("read returned wrong data or had side effect");

  a_rdata_holds: assert property (
    @(posedge clk) disable iff (rst)
    !req.rd |=> $stable(rdata_q))
    else $error("read data changed without a read");

endmodule // buck_setpoint_registers
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import buck_setpoint_pkg::*;
(
  input  wire logic     clk,
  output var reg_req_t  req,
  output var logic      unlock_ok
);
  initial begin
    req = '0;
    unlock_ok = 1'b0;
  end
  // Drives one single-cycle access just after a rising edge.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, input logic u);
    @(posedge clk);
    #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    unlock_ok = u;
    @(posedge clk);
    #1;
    req = '0;
    unlock_ok = 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// file: sim/buck_setpoint_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module buck_setpoint_registers_tb;
  import buck_setpoint_pkg::*;
  logic         clk;
  logic         rst;
  reg_req_t     req;
  logic         unlock_ok;
  logic [7:0]   rdata_q;
  buck_target_t buck2_q;
  buck_target_t buck3_q;
  int           n_fail = 0;
  int           n_checks = 0;
  int           cycles = 0;
  logic [5:0]   codes [8] = '{6'h00, 6'h17, 6'h18, 6'h2F,
                              6'h30, 6'h35, 6'h37, 6'h3F};
  logic [11:0]  tbl [8] = '{12'hA8C, 12'hABE, 12'hAF0, 12'hB22,
                            12'hB54, 12'hBB8, 12'hC1C, 12'hC80};
  buck_setpoint_registers #(.VARIANT_HIGH_RESET(1'b0))
    buck_setpoint_registers_inst (.clk(clk), .rst(rst), .req(req),
    .unlock_ok(unlock_ok), .rdata_q(rdata_q), .buck2_q(buck2_q),
    .buck3_q(buck3_q));
  host_model host_model_inst (.clk(clk), .req(req), .unlock_ok(unlock_ok));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [11:0] mv(input logic [5:0] c);
    if (c < 6'h18) return 12'h384 + 12'h019 * {6'h00, c};
    if (c < 6'h30) return 12'h5DC + 12'h032 * {6'h00, c - 6'h18};
    if (c < 6'h38) return tbl[c[2:0]];
    return 12'hCE4;
  endfunction
  task automatic chk(input string what, input logic [11:0] e,
                     input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string what);
    host_model_inst.access(1'b0, a, 8'h00, 1'b0);
    chk(what, {4'h0, e}, {4'h0, rdata_q});
  endtask
  // Writes, then lets the decoded target settle one more edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    host_model_inst.access(1'b1, a, d, u);
    @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    rd(8'h10, 8'h08, "buck3 reset");
    rd(8'h0F, 8'h08, "buck2 reset");
    chk("buck3 mv", 12'h44C, buck3_q.target_mv);
    $display("test reset done");
    wr(8'h10, 8'hC5, 1'b1);
    rd(8'h10, 8'h85, "reserved bit");
    chk("buck3 ext", 12'h001, {11'h000, buck3_q.external});
    chk("buck3 ignored", 12'h000, buck3_q.target_mv);
    wr(8'h10, 8'h3F, 1'b0);
    rd(8'h10, 8'h85, "locked write");
    rd(8'h10, 8'h85, "read repeat");
    rd(8'h11, 8'h00, "unmapped");
    wr(8'h11, 8'h3F, 1'b1);
    rd(8'h10, 8'h85, "unmapped write");
    wr(8'h0F, 8'hC5, 1'b1);
    chk("buck2 ext", 12'h001, {11'h000, buck2_q.external});
    chk("buck2 ignored", 12'h000, buck2_q.target_mv);
    wr(8'h0F, 8'h3F, 1'b0);
    rd(8'h0F, 8'h85, "buck2 locked");
    $display("test access done");
    foreach (codes[i]) begin
      wr(8'h0F, {2'b00, codes[i]}, 1'b1);
      chk("buck2 mv", mv(codes[i]), buck2_q.target_mv);
      wr(8'h10, {2'b00, codes[i]}, 1'b1);
      chk("buck3 mv", mv(codes[i]), buck3_q.target_mv);
    end
    $display("test decode done");
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(8'h10, 8'h08, "buck3 again");
    chk("buck2 again", 12'h44C, buck2_q.target_mv);
    $display("test reset again done");
    complete_run();
  end
endmodule // buck_setpoint_registers_tb
`default_nettype wire
